// >>> hw/ssw_pkg.sv
// package: constants, types and contract summary for the supply supervisor watchdog
// Contract
// [R1] reset output held low while the supply flag reports below trip level
// [R2] reset held a further hold period after supply recovers or watchdog expires
// [R3] full timeout without a clear asserts reset for the hold period
// [R4] every rising and falling strobe edge clears the timer; static levels are no service
// [R5] a 50 ns strobe pulse is seen as two valid transitions
// [R6] any generated reset clears the watchdog timer
// [R7] timer held at zero while reset is asserted; counts again after release
// [R8] a floating or high-impedance strobe disables the watchdog
// [R9] reset output active low; build option picks push-pull or open-drain drive
// [R10] host must toggle the strobe faster than the timeout while enabled
// [R11] unconnected strobe blocks the expiry path so expiry never asserts reset
// [R12] timeout and hold period are build parameters in clock cycles
// [R13] strobe and undervoltage flag are synchronised before use
package ssw_pkg;

    localparam int unsigned CLK_PERIOD_PS   = 8000;
    localparam int unsigned STROBE_PULSE_NS = 50;
    // a 50 ns pulse spans at least this many whole clocks, so both edges get sampled
    localparam int unsigned STROBE_PULSE_CYC =
        (STROBE_PULSE_NS * 1000) / CLK_PERIOD_PS;
    // shortest timeout and hold options: 4.3 ms strobe timeout, 1 ms hold, at 125 MHz
    localparam int unsigned TIMEOUT_DEF_CYC = 537500;
    localparam int unsigned HOLD_DEF_CYC    = 125000;
    localparam int unsigned CNT_W           = 32;
    localparam int unsigned SYNC_STAGES     = 2;

    typedef enum logic [1:0] {
        SSW_RUN   = 2'b00,
        SSW_UV    = 2'b01,
        SSW_HOLD  = 2'b10
    } ssw_state_t;

    typedef struct packed {
        logic strobe;
        logic strobe_float;
        logic supply_low;
    } ssw_in_t;

    typedef struct packed {
        ssw_state_t       state;
        logic [CNT_W-1:0] wd_cnt;
        logic [CNT_W-1:0] hold_cnt;
        logic             strobe_prev;
        logic             expired;
        logic             rst_n_out;
        logic             rst_oe;
    } ssw_regs_t;

endpackage

// >>> hw/ssw_sync.sv
// two-flop synchroniser bank for the asynchronous control inputs
`timescale 1ns/1ps
module ssw_sync
    import ssw_pkg::*;
#(
    parameter int unsigned WIDTH = 3
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             nrst,
    // data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff;

    // first stage feeds only the second
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d; // R13
            q       <= meta_ff;
        end
    end
endmodule

// >>> hw/ssw_top.sv
// supply supervisor with strobe watchdog driving an active-low reset
`timescale 1ns/1ps
module ssw_top
    import ssw_pkg::*;
#(
    parameter int unsigned STROBE_TIMEOUT    = TIMEOUT_DEF_CYC,
    parameter int unsigned RESET_HOLD_PERIOD = HOLD_DEF_CYC,
    parameter bit          OPEN_DRAIN        = 1'b0
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic nrst,
    // monitored inputs
    input  wire logic supply_low,
    input  wire logic watchdog_strobe_in,
    input  wire logic strobe_floating,
    // reset output pin
    output logic      host_rst_n_o,
    output logic      host_rst_oe
);
    localparam logic [CNT_W-1:0] TMO_LAST  = CNT_W'(STROBE_TIMEOUT - 1);  // R12
    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(RESET_HOLD_PERIOD - 1);

    ssw_in_t   raw_in;
    ssw_in_t   syn;
    ssw_regs_t r_ff;
    ssw_regs_t nxt_r;
    logic      strobe_edge;

    assign raw_in = '{strobe: watchdog_strobe_in, strobe_float: strobe_floating,
                      supply_low: supply_low};

    ssw_sync #(.WIDTH($bits(ssw_in_t))) u_sync (
        .mclk (mclk),
        .nrst (nrst),
        .d    (raw_in),
        .q    (syn)
    );

    // either polarity counts as service; 8 ns sampling resolves a 50 ns pulse
    assign strobe_edge = syn.strobe ^ r_ff.strobe_prev; // R4 R5

    function automatic logic [CNT_W-1:0] cnt_inc(input logic [CNT_W-1:0] c);
        cnt_inc = c + CNT_W'(1);
    endfunction

    always_comb begin
        nxt_r             = r_ff;
        nxt_r.strobe_prev = syn.strobe;
        nxt_r.expired     = 1'b0;
        unique case (r_ff.state)
            SSW_RUN: begin
                if (syn.supply_low) begin
                    nxt_r.state  = SSW_UV; // R1
                    nxt_r.wd_cnt = '0;     // R6
                end else if (syn.strobe_float || strobe_edge) begin
                    nxt_r.wd_cnt = '0;     // R4 R8
                end else if (r_ff.wd_cnt == TMO_LAST) begin
                    nxt_r.state    = SSW_HOLD; // R3
                    nxt_r.wd_cnt   = '0;       // R6
                    nxt_r.hold_cnt = '0;
                    nxt_r.expired  = 1'b1;
                end else begin
                    nxt_r.wd_cnt = cnt_inc(r_ff.wd_cnt);
                end
            end
            SSW_UV: begin
                nxt_r.wd_cnt   = '0; // R7
                nxt_r.hold_cnt = '0;
                if (!syn.supply_low) begin
                    nxt_r.state = SSW_HOLD; // R2
                end
            end
            SSW_HOLD: begin
                nxt_r.wd_cnt = '0; // R7
                if (syn.supply_low) begin
                    nxt_r.state = SSW_UV; // R1
                end else if (r_ff.hold_cnt == HOLD_LAST) begin
                    nxt_r.state = SSW_RUN; // R2
                end else begin
                    nxt_r.hold_cnt = cnt_inc(r_ff.hold_cnt);
                end
            end
            default: begin
                nxt_r.state = SSW_UV;
            end
        endcase
        // floating strobe keeps expiry off the reset path
        nxt_r.rst_n_out = (nxt_r.state == SSW_RUN);        // R9 R11
        nxt_r.rst_oe    = OPEN_DRAIN ? !nxt_r.rst_n_out : 1'b1; // R9
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            r_ff <= '{state: SSW_HOLD, wd_cnt: '0, hold_cnt: '0, strobe_prev: 1'b0,
                      expired: 1'b0, rst_n_out: 1'b0, rst_oe: 1'b1};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign host_rst_n_o = r_ff.rst_n_out;
    assign host_rst_oe  = r_ff.rst_oe;

    sequence s_recover;
        r_ff.state == SSW_UV ##1 r_ff.state == SSW_HOLD;
    endsequence

    uv_holds_rst_a: assert property (@(posedge mclk) disable iff (!nrst) // R1
        r_ff.state == SSW_UV |-> !host_rst_n_o)
        else $error("reset released during undervoltage");

    hold_entry_a: assert property (@(posedge mclk) disable iff (!nrst) // R2
        s_recover |-> !host_rst_n_o && r_ff.hold_cnt == '0)
        else $error("hold period did not start cleanly");

    hold_end_a: assert property (@(posedge mclk) disable iff (!nrst) // R2
        r_ff.state == SSW_HOLD && r_ff.hold_cnt != HOLD_LAST && !syn.supply_low
        |=> r_ff.state == SSW_HOLD)
        else $error("hold ended early");

    expiry_rst_a: assert property (@(posedge mclk) disable iff (!nrst) // R3
        r_ff.expired |-> r_ff.state == SSW_HOLD && !host_rst_n_o)
        else $error("expiry without reset");

    edge_clear_a: assert property (@(posedge mclk) disable iff (!nrst) // R4
        r_ff.state == SSW_RUN && !syn.supply_low && strobe_edge |=> r_ff.wd_cnt == '0)
        else $error("strobe edge did not clear timer");

    cnt_zero_rst_a: assert property (@(posedge mclk) disable iff (!nrst) // R7
        r_ff.state != SSW_RUN |-> r_ff.wd_cnt == '0)
        else $error("timer moved during reset");

    float_block_a: assert property (@(posedge mclk) disable iff (!nrst) // R11
        syn.strobe_float && r_ff.state == SSW_RUN |=> !r_ff.expired)
        else $error("expiry while strobe floating");

    drive_mode_a: assert property (@(posedge mclk) disable iff (!nrst) // R9
        OPEN_DRAIN ? (host_rst_oe == !host_rst_n_o) : host_rst_oe)
        else $error("reset drive mode wrong");

    uv_clear_a: assert property (@(posedge mclk) disable iff (!nrst) // R6
        $rose(r_ff.state == SSW_UV) |-> r_ff.wd_cnt == '0)
        else $error("undervoltage did not clear timer");

    // running with no service and no floating pin: the timer must climb
    sequence s_unserved;
        r_ff.state == SSW_RUN && !syn.supply_low && !syn.strobe_float && !strobe_edge;
    endsequence

    // the last count of an unserved run: expiry is due on the next edge
    sequence s_starved;
        s_unserved ##0 r_ff.wd_cnt == TMO_LAST;
    endsequence

    uv_entry_a: assert property (@(posedge mclk) disable iff (!nrst) // R1
        r_ff.state == SSW_RUN && syn.supply_low
        |=> r_ff.state == SSW_UV && !host_rst_n_o)
        else $error("undervoltage not entered");

    uv_stay_a: assert property (@(posedge mclk) disable iff (!nrst) // R1
        r_ff.state == SSW_UV && syn.supply_low |=> r_ff.state == SSW_UV)
        else $error("left undervoltage while supply low");

    uv_from_hold_a: assert property (@(posedge mclk) disable iff (!nrst) // R1
        r_ff.state == SSW_HOLD && syn.supply_low |=> r_ff.state == SSW_UV)
        else $error("supply drop during hold ignored");

    hold_release_a: assert property (@(posedge mclk) disable iff (!nrst) // R2
        r_ff.state == SSW_HOLD && r_ff.hold_cnt == HOLD_LAST && !syn.supply_low
        |=> r_ff.state == SSW_RUN && host_rst_n_o)
        else $error("hold did not release");

    expire_entry_a: assert property (@(posedge mclk) disable iff (!nrst) // R3
        s_starved |=> r_ff.expired && r_ff.state == SSW_HOLD)
        else $error("timeout without expiry");

    count_step_a: assert property (@(posedge mclk) disable iff (!nrst) // R3
        s_unserved ##0 r_ff.wd_cnt != TMO_LAST
        |=> r_ff.wd_cnt == $past(r_ff.wd_cnt) + CNT_W'(1))
        else $error("timer did not advance");

    no_early_exp_a: assert property (@(posedge mclk) disable iff (!nrst) // R3
        r_ff.expired |-> $past(r_ff.wd_cnt) == TMO_LAST)
        else $error("expiry before full timeout");

    exp_pulse_a: assert property (@(posedge mclk) disable iff (!nrst) // R3
        r_ff.expired |=> !r_ff.expired)
        else $error("expiry flag stuck");

    // the edge detector must see the synchronised level of the previous cycle
    strobe_track_a: assert property (@(posedge mclk) disable iff (!nrst) // R4
        r_ff.strobe_prev == $past(syn.strobe))
        else $error("strobe history lost");

    float_clear_a: assert property (@(posedge mclk) disable iff (!nrst) // R8
        syn.strobe_float && r_ff.state == SSW_RUN && !syn.supply_low
        |=> r_ff.wd_cnt == '0)
        else $error("floating strobe let timer run");

    rst_clear_a: assert property (@(posedge mclk) disable iff (!nrst) // R6
        $fell(host_rst_n_o) |-> r_ff.wd_cnt == '0)
        else $error("reset did not clear timer");
endmodule

// >>> tb/ssw_host_model.sv
// host model that strobes the watchdog input at a fixed cadence
`timescale 1ns/1ps
module ssw_host_model
    import ssw_pkg::*;
#(
    parameter int GAP = 7
) (
    // clock
    input  wire logic mclk,
    // control
    input  wire logic serve,
    input  wire logic hiz,
    // strobe pin
    output logic      strobe
);
    int   cnt = 0;
    logic drv = 1'b0;
    initial strobe = 1'b0;
    // 7 clocks is 56 ns a level, the shortest whole-clock pulse above 50 ns
    always @(negedge mclk) begin
        cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
        if (hiz) begin
            // released pin shows the inverse, never the last value
            strobe <= ~drv;
        end else if (serve && cnt == GAP - 1) begin
            drv    <= ~drv;
            strobe <= ~drv;
        end else begin
            strobe <= drv;
        end
    end
endmodule

// >>> tb/ssw_top_bench.sv
// self-checking bench for the supply supervisor watchdog
`timescale 1ns/1ps
module ssw_top_bench;
    import ssw_pkg::*;
    localparam int TO = 20;
    localparam int HP = 8;
    logic mclk, nrst, supply_low, strobe_floating, serve, hiz, strobe, rst_n, oe;
    logic pp_rst, pp_oe;
    int   fail_count = 0;
    int   tests_run  = 0;
    // open-drain pin with pull-up
    wire  pin = oe ? rst_n : 1'b1;
    ssw_top #(.STROBE_TIMEOUT(TO), .RESET_HOLD_PERIOD(HP), .OPEN_DRAIN(1'b1)) i_ssw_top (
        .mclk(mclk), .nrst(nrst), .supply_low(supply_low), .watchdog_strobe_in(strobe),
        .strobe_floating(strobe_floating), .host_rst_n_o(rst_n), .host_rst_oe(oe));
    // push-pull twin on the same inputs; its level must match the pulled-up pin
    ssw_top #(.STROBE_TIMEOUT(TO), .RESET_HOLD_PERIOD(HP), .OPEN_DRAIN(1'b0)) i_ssw_top_pp (
        .mclk(mclk), .nrst(nrst), .supply_low(supply_low), .watchdog_strobe_in(strobe),
        .strobe_floating(strobe_floating), .host_rst_n_o(pp_rst), .host_rst_oe(pp_oe));
    ssw_host_model i_ssw_host_model (.mclk(mclk), .serve(serve), .hiz(hiz), .strobe(strobe));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic wait_pin(input logic lvl, output int n);
        n = 0;
        while (pin !== lvl && n < 300) begin
            @(negedge mclk);
            n++;
        end
    endtask
    task automatic steady(input int cyc);
        logic bad;
        logic bad_pp;
        bad = 1'b0;
        bad_pp = 1'b0;
        repeat (cyc) begin
            @(negedge mclk);
            bad |= (pin !== 1'b1);
            bad_pp |= (pp_rst !== 1'b1) || (pp_oe !== 1'b1);
        end
        check(!bad, "unexpected reset");
        check(!bad_pp, "push-pull output wrong");
    endtask
    task automatic t_por();
        int n;
        check(pin === 1'b0 && oe === 1'b1, "not low after reset");
        wait_pin(1'b1, n);
        check(n >= HP && n <= HP + 4, "power-on hold length");
        check(oe === 1'b0, "open-drain still driving");
        check(pp_oe === 1'b1 && pp_rst === pin, "push-pull pin differs");
        $display("done por");
    endtask
    task automatic t_expire();
        int n;
        serve = 1'b0;
        wait_pin(1'b0, n);
        check(n >= TO - 8 && n <= TO + 6, "expiry time");
        wait_pin(1'b1, n);
        check(n >= HP && n <= HP + 3, "hold after expiry");
        wait_pin(1'b0, n);
        check(n >= TO - 1 && n <= TO + 3, "timer not cleared by reset");
        wait_pin(1'b1, n);
        check(n >= HP && n <= HP + 3, "hold after second expiry");
        serve = 1'b1;
        $display("done expire");
    endtask
    task automatic t_uv();
        int n;
        logic bad;
        bad = 1'b0;
        supply_low = 1'b1;
        wait_pin(1'b0, n);
        check(n >= 2 && n <= 4, "undervoltage latency");
        repeat (3 * TO) begin
            @(negedge mclk);
            bad |= (pin !== 1'b0);
        end
        check(!bad, "released while supply low");
        supply_low = 1'b0;
        wait_pin(1'b1, n);
        check(n >= HP + 2 && n <= HP + 6, "hold after recovery");
        $display("done uv");
    endtask
    task automatic t_float();
        serve = 1'b0;
        hiz = 1'b1;
        strobe_floating = 1'b1;
        steady(4 * TO);
        strobe_floating = 1'b0;
        hiz = 1'b0;
        serve = 1'b1;
        $display("done float");
    endtask
    task automatic conclude();
        $display("tests %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        nrst = 1'b0;
        supply_low = 1'b0;
        strobe_floating = 1'b0;
        serve = 1'b1;
        hiz = 1'b0;
        repeat (12) @(negedge mclk);
        nrst = 1'b1;
        t_por();
        steady(10 * TO);
        $display("done serve");
        t_expire();
        t_uv();
        t_float();
        conclude();
    end
    // whole run is about 440 clocks; the 6000-clock limit allows over ten times that
    initial begin
        #48000;
        fail_count++;
        conclude();
    end
endmodule
